// [crc4_map.svh]
`ifndef CRC4_MAP_SVH
`define CRC4_MAP_SVH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_CMD       8'h04
`define OFS_TX_SPARE  8'h08
`define OFS_STATUS    8'h0c
`define OFS_IRQ       8'h10
`define OFS_MASK      8'h14
`define OFS_CEC       8'h18
`define OFS_TX_SA     8'h20
`define OFS_RX_SA     8'h40

// command bit positions
`define CMD_FULL_BIT  0
`define CMD_MF_BIT    1

// frame structure
`define TS0_BITS      8
`define NAT_BITS      5
`define NAT_FIRST_POS 3'h3
`define MFA_PATTERN   6'h0b
`define MFA_LAST      4'hb
`define FAS_WORD      7'h1b
`define E13_FRAME     4'hd
`define E15_FRAME     4'hf
`define LAST_FRAME    4'hf
`define LAST_POS      3'h7
`define CRC_SEED      4'h0
`define CRC_POLY      4'h3
`define SMF_SEEN_FULL 2'h2

// timing, in milliseconds, frames of FRAME_US microseconds
`define FRAME_US      125
`define SPACING_MS    2
`define SEARCH_MS     8
`define RELOAD_MS     6

`endif

// [crc4_pkg.sv]
package crc4_pkg;

  typedef struct packed {
    logic [4:0] hdlc_sa_sel;
    logic       national_bits_transparent;
    logic       alarm_bit_transparent;
    logic       si_input_transparent;
    logic       si_fifo_transparent;
    logic       full_ts0_transparent;
    logic       national_regs_en;
    logic       auto_alarm_en;
    logic       auto_ebit_en;
    logic       auto_force_resync_en;
    logic       force_crc_invert;
    logic       auto_crc_invert_en;
    logic       mf_en;
  } ctrl_t;

  typedef struct packed {
    logic [4:0] tx_national_word_bits;
    logic       tx_si_bit;
    logic       tx_remote_alarm_bit;
    logic       tx_ebit_frame15;
    logic       tx_ebit_frame13;
  } tx_spare_t;

  typedef struct packed {
    logic rx_ebit_frame15;
    logic rx_ebit_frame13;
    logic multiframe_align_lost_flag;
    logic frame_align_lost_flag;
  } status_t;

  typedef struct packed {
    logic search_window_timeout_status;
    logic multiframe_recovery_irq_status;
    logic frame_recovery_irq_status;
    logic multiframe_loss_irq_status;
    logic frame_loss_irq_status;
    logic crc_error_irq_status;
  } irq_t;

  typedef enum logic [1:0] {
    MF_IDLE,
    MF_SEARCH,
    MF_ONE,
    MF_SYNC
  } mf_state_t;

endpackage : crc4_pkg

// [crc4_lfsr.sv]
`include "crc4_map.svh"

// serial crc4 (x^4 + x + 1) over one block, restart on clear_in
module crc4_lfsr (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       clear_in,
  input  wire logic       shift_in,
  input  wire logic       data_in,
  output logic      [3:0] crc_out
);

  logic [3:0] base;
  logic       feedback;
  logic [3:0] shifted;
  logic [3:0] next_crc;

  assign base     = clear_in ? `CRC_SEED : crc_out;
  assign feedback = base[3] ^ data_in;
  assign shifted  = {base[2:0], 1'b0} ^ (feedback ? `CRC_POLY : 4'h0);
  assign next_crc = shift_in ? shifted : base;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      crc_out <= `CRC_SEED;
    end else begin
      crc_out <= next_crc;
    end
  end

endmodule : crc4_lfsr

// [crc4_multiframe_align.sv]
// Overview of operation
// - sixteen frames, two submultiframes, c bits even
// - odd frames 1..11 carry pattern 001011
// - crc4 computed over each 2048 bit submultiframe
// - e bits readable, sent from spare bits
// - automatic submultiframe error indication in e bits
// - per bit national registers, hdlc selectable
// - remote alarm bit, optional automatic generation
// - internal framing, or full ts0 from input
// - partial transparent modes pick their input bits
// - crc auto enabled, 16 bit error counter
// - crc error status gated by its mask
// - auto invert crc after received errored block
// - force invert ored with auto invert
// - frame loss sets mf loss, edge statuses
// - mf search restarts on frame recovery
// - full or multiframe only forced resync
// - check after first pattern, count only synced
// - sync after two patterns n times 2ms
// - auto force resync after 8ms without sync
// - 8ms window, 6ms after each pattern until sync, timeout
//
// The placing of the registers and register access over APB were left to the implementer.
`include "crc4_map.svh"

module crc4_multiframe_align
  import crc4_pkg::*;
#(
  parameter int CEC_WIDTH = 16
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        rx_bit_en_in,
  input  wire logic        rx_frame_start_in,
  input  wire logic        rx_fas_frame_in,
  input  wire logic        rx_data_in,
  input  wire logic        frame_align_lost_in,
  input  wire logic        frame_recovery_in,
  input  wire logic        tx_bit_en_in,
  input  wire logic        tx_frame_start_in,
  input  wire logic        system_tx_data_in,
  input  wire logic        hdlc_tx_data_in,
  output logic             hdlc_tx_take_out,
  output logic             tx_data_out,
  output logic             multiframe_align_lost_out,
  output logic             frame_resync_req_out
);

  localparam int SEARCH_FRAMES = `SEARCH_MS * 1000 / `FRAME_US;
  localparam int RELOAD_FRAMES = `RELOAD_MS * 1000 / `FRAME_US;
  localparam int SPACE_FRAMES  = `SPACING_MS * 1000 / `FRAME_US;
  localparam int TW = $clog2(SEARCH_FRAMES + 1);
  localparam logic [7:0] TX_SA_BASE = `OFS_TX_SA;
  localparam logic [7:0] RX_SA_BASE = `OFS_RX_SA;
  localparam logic [5:0] MFA_WORD   = `MFA_PATTERN;
  localparam logic [6:0] FAS_BITS   = `FAS_WORD;

  ctrl_t                ctrl;
  tx_spare_t            tx_spare;
  irq_t                 irq;
  logic                 crc_error_irq_mask;
  logic [CEC_WIDTH-1:0] crc_error_counter;
  logic [7:0]           tx_national_bit_regs [`NAT_BITS];
  logic [7:0]           rx_national_bit_regs [`NAT_BITS];
  logic [7:0]           rx_sa_shift [`NAT_BITS];
  mf_state_t            state;
  mf_state_t            next_state;
  logic [TW-1:0]        search_timer;
  logic [TW-1:0]        next_timer;
  logic [7:0]           rx_pos;
  logic [3:0]           rx_frame;
  logic [5:0]           mfa_shift;
  logic [3:0]           c_rx;
  logic [3:0]           crc_ref;
  logic [1:0]           smf_seen;
  logic                 rx_err_last;
  logic                 rx_ebit_frame13;
  logic                 rx_ebit_frame15;
  logic                 lfa_q;
  logic [7:0]           tx_pos;
  logic [3:0]           tx_frame;
  logic [3:0]           tx_crc_ref;
  logic                 tx_inv;

  // apb decode
  wire       setup    = psel_in & ~penable_in;
  wire       wr       = psel_in & penable_in & pwrite_in;
  wire [2:0] sa_idx   = paddr_in[4:2];
  wire       sa_ok    = (sa_idx < 3'(`NAT_BITS)) & (paddr_in[1:0] == 2'h0);
  wire       tx_sa_hit = sa_ok & (paddr_in[7:5] == TX_SA_BASE[7:5]);
  wire       rx_sa_hit = sa_ok & (paddr_in[7:5] == RX_SA_BASE[7:5]);
  wire       hit_ctrl = paddr_in == `OFS_CTRL;
  wire       hit_cmd  = paddr_in == `OFS_CMD;
  wire       hit_sp   = paddr_in == `OFS_TX_SPARE;
  wire       hit_st   = paddr_in == `OFS_STATUS;
  wire       hit_irq  = paddr_in == `OFS_IRQ;
  wire       hit_mask = paddr_in == `OFS_MASK;
  wire       hit_cec  = paddr_in == `OFS_CEC;
  wire       hit_any  = hit_ctrl | hit_cmd | hit_sp | hit_st | hit_irq |
                        hit_mask | hit_cec | tx_sa_hit | rx_sa_hit;
  wire       cmd_full = wr & hit_cmd & pwdata_in[`CMD_FULL_BIT];
  wire       cmd_mf   = wr & hit_cmd & pwdata_in[`CMD_MF_BIT];

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit_any;

  // receive position tracking
  wire       rs        = rx_bit_en_in;
  wire [7:0] rcur_pos  = rx_frame_start_in ? 8'h00 : 8'(rx_pos + 8'h01);
  wire [3:0] rcur_fr   = rx_frame_start_in ? 4'(rx_frame + 4'h1) : rx_frame;
  wire       r_ts0     = rcur_pos < 8'(`TS0_BITS);
  wire [2:0] r_p       = rcur_pos[2:0];
  wire       aligned   = (state == MF_ONE) | (state == MF_SYNC);
  wire       r_cpos    = r_ts0 & (r_p == 3'h0) & ~rcur_fr[0];
  wire       nfas_b1   = rs & rx_frame_start_in & ~rx_fas_frame_in;
  wire [5:0] mfa_new   = {mfa_shift[4:0], rx_data_in};
  wire       mfa_hit   = nfas_b1 & (mfa_new == `MFA_PATTERN);
  // frame counter wraps every SPACE_FRAMES, so a hit on the same slot
  // is n times 2ms after the previous one
  wire       spaced    = rcur_fr == `MFA_LAST;
  wire       smf_start = rs & rx_frame_start_in & (rcur_fr[2:0] == 3'h0);
  wire       smf_err   = smf_start & aligned & (smf_seen == `SMF_SEEN_FULL) &
                         (c_rx != crc_ref);
  wire       searching = (state == MF_SEARCH) | (state == MF_ONE);
  wire       timeout   = searching & rs & rx_frame_start_in &
                         (search_timer == TW'(1));
  wire       restart   = frame_recovery_in | cmd_mf;
  wire [3:0] rx_crc;

  crc4_lfsr u_rx_crc (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .clear_in (smf_start),
    .shift_in (rs),
    .data_in  (r_cpos ? 1'b0 : rx_data_in),
    .crc_out  (rx_crc)
  );

  always_comb begin
    next_state = state;
    next_timer = search_timer;
    if (searching & rs & rx_frame_start_in) begin
      next_timer = TW'(search_timer - TW'(1));
    end
    case (state)
      MF_IDLE: begin
        if (~frame_align_lost_in) begin
          next_state = MF_SEARCH;
          next_timer = TW'(SEARCH_FRAMES);
        end
      end
      MF_SEARCH: begin
        if (mfa_hit) begin
          next_state = MF_ONE;
          next_timer = TW'(RELOAD_FRAMES);
        end
      end
      MF_ONE: begin
        if (mfa_hit & spaced) begin
          next_state = MF_SYNC;
        end else if (mfa_hit) begin
          next_timer = TW'(RELOAD_FRAMES);
        end
      end
      MF_SYNC: begin
        next_state = MF_SYNC;
      end
      default: begin
        next_state = MF_IDLE;
      end
    endcase
    if (timeout & next_state != MF_SYNC) begin
      next_state = MF_SEARCH;
      next_timer = TW'(SEARCH_FRAMES);
    end
    if (restart) begin
      next_state = MF_SEARCH;
      next_timer = TW'(SEARCH_FRAMES);
    end
    if (~ctrl.mf_en | frame_align_lost_in | cmd_full) begin
      next_state = MF_IDLE;
    end
  end

  wire lmfa_next = next_state != MF_SYNC;
  wire lmfa_rise = lmfa_next & ~multiframe_align_lost_out;
  wire lmfa_fall = ~lmfa_next & multiframe_align_lost_out;
  wire lfa_rise  = frame_align_lost_in & ~lfa_q;
  wire resync    = cmd_full | (timeout & ctrl.auto_force_resync_en);

  irq_t irq_set;
  assign irq_set = '{
    search_window_timeout_status:   timeout,
    multiframe_recovery_irq_status: lmfa_fall,
    frame_recovery_irq_status:      frame_recovery_in,
    multiframe_loss_irq_status:     lmfa_rise,
    frame_loss_irq_status:          lfa_rise,
    crc_error_irq_status:           smf_err & crc_error_irq_mask
  };
  wire [5:0] irq_clr = (wr & hit_irq) ? pwdata_in[5:0] : 6'h00;
  wire       cec_inc = smf_err & (state == MF_SYNC);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state                     <= MF_IDLE;
      search_timer              <= '0;
      multiframe_align_lost_out <= 1'b1;
      frame_resync_req_out      <= 1'b0;
      lfa_q                     <= 1'b0;
      irq                       <= '0;
    end else begin
      state                     <= next_state;
      search_timer              <= next_timer;
      multiframe_align_lost_out <= lmfa_next;
      frame_resync_req_out      <= resync;
      lfa_q                     <= frame_align_lost_in;
      irq                       <= (irq & ~irq_clr) | irq_set;
    end
  end

  // receive crc check and spare bits
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_pos      <= '0;
      rx_frame    <= '0;
      mfa_shift   <= '0;
      c_rx        <= '0;
      crc_ref     <= '0;
      smf_seen    <= '0;
      rx_err_last <= 1'b0;
    end else if (rs) begin
      rx_pos   <= rcur_pos;
      rx_frame <= (mfa_hit & state != MF_SYNC) ? `MFA_LAST : rcur_fr;
      if (nfas_b1) begin
        mfa_shift <= mfa_new;
      end
      if (r_cpos) begin
        c_rx <= {c_rx[2:0], rx_data_in};
      end
      if (mfa_hit & state != MF_SYNC) begin
        smf_seen <= '0;
      end else if (smf_start) begin
        crc_ref     <= rx_crc;
        rx_err_last <= smf_err;
        if (smf_seen != `SMF_SEEN_FULL) begin
          smf_seen <= 2'(smf_seen + 2'h1);
        end
      end
    end
  end

  wire e_slot = rs & aligned & r_ts0 & (r_p == 3'h0);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_ebit_frame13 <= 1'b1;
      rx_ebit_frame15 <= 1'b1;
    end else begin
      if (e_slot & rcur_fr == `E13_FRAME) begin
        rx_ebit_frame13 <= rx_data_in;
      end
      if (e_slot & rcur_fr == `E15_FRAME) begin
        rx_ebit_frame15 <= rx_data_in;
      end
    end
  end

  // transmit position and crc
  wire       ts        = tx_bit_en_in;
  wire [7:0] tcur_pos  = tx_frame_start_in ? 8'h00 : 8'(tx_pos + 8'h01);
  wire [3:0] tf        = tx_frame_start_in ? 4'(tx_frame + 4'h1) : tx_frame;
  wire       t_ts0     = tcur_pos < 8'(`TS0_BITS);
  wire [2:0] tp        = tcur_pos[2:0];
  wire       t_cpos    = t_ts0 & (tp == 3'h0) & ~tf[0];
  wire       tx_smf    = ts & tx_frame_start_in & (tf[2:0] == 3'h0);
  wire [3:0] tx_crc;
  wire [3:0] cref_eff  = tx_smf ? tx_crc : tx_crc_ref;
  wire       inv_new   = ctrl.force_crc_invert |
                         (ctrl.auto_crc_invert_en & rx_err_last);
  wire       inv_eff   = tx_smf ? inv_new : tx_inv;
  wire       cbit      = cref_eff[2'h3 - tf[2:1]] ^ inv_eff;
  wire       auto_e    = ctrl.auto_ebit_en | ctrl.si_fifo_transparent;
  wire       e13       = auto_e ? ~rx_err_last : tx_spare.tx_ebit_frame13;
  wire       e15       = auto_e ? ~rx_err_last : tx_spare.tx_ebit_frame15;
  wire       a_bit     = ctrl.auto_alarm_en ? frame_align_lost_in :
                         tx_spare.tx_remote_alarm_bit;
  wire [2:0] sa_k      = 3'(tp - `NAT_FIRST_POS);
  wire [4:0] sa_src;
  wire [4:0] hdlc_use;

  genvar k;
  generate
    for (k = 0; k < `NAT_BITS; k++) begin : g_nat
      assign sa_src[k] = ctrl.hdlc_sa_sel[k] ? hdlc_tx_data_in :
                         ctrl.national_regs_en ?
                         tx_national_bit_regs[k][3'h7 - tf[3:1]] :
                         tx_spare.tx_national_word_bits[k];
      assign hdlc_use[k] = ctrl.hdlc_sa_sel[k] & (sa_k == 3'(k));

      // receive national bits, latched once per multiframe
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          rx_sa_shift[k]          <= '0;
          rx_national_bit_regs[k] <= '0;
        end else if (rs & aligned & r_ts0 & rcur_fr[0] &
                     r_p == 3'(`NAT_FIRST_POS + 3'(k))) begin
          rx_sa_shift[k] <= {rx_sa_shift[k][6:0], rx_data_in};
          if (rcur_fr == `LAST_FRAME) begin
            rx_national_bit_regs[k] <= {rx_sa_shift[k][6:0], rx_data_in};
          end
        end
      end
    end
  endgenerate

  logic int_bit;
  logic tx_next;
  logic sa_slot;

  always_comb begin
    sa_slot = 1'b0;
    int_bit = system_tx_data_in;
    if (tp == 3'h0) begin
      if (~tf[0]) begin
        int_bit = ctrl.mf_en ? cbit : tx_spare.tx_si_bit;
      end else if (~ctrl.mf_en) begin
        int_bit = tx_spare.tx_si_bit;
      end else if (tf == `E13_FRAME) begin
        int_bit = ctrl.si_input_transparent ? system_tx_data_in : e13;
      end else if (tf == `E15_FRAME) begin
        int_bit = ctrl.si_input_transparent ? system_tx_data_in : e15;
      end else begin
        int_bit = MFA_WORD[3'h5 - tf[3:1]];
      end
    end else if (~tf[0]) begin
      int_bit = FAS_BITS[3'h7 - tp];
    end else if (tp == 3'h1) begin
      int_bit = 1'b1;
    end else if (tp == 3'h2) begin
      int_bit = ctrl.alarm_bit_transparent ? system_tx_data_in : a_bit;
    end else begin
      sa_slot = ~ctrl.national_bits_transparent;
      int_bit = ctrl.national_bits_transparent ? system_tx_data_in :
                sa_src[sa_k];
    end
    tx_next = (t_ts0 & ~ctrl.full_ts0_transparent) ? int_bit :
              system_tx_data_in;
  end

  assign hdlc_tx_take_out = ts & t_ts0 & tf[0] & sa_slot &
                            ~ctrl.full_ts0_transparent & (|hdlc_use);

  crc4_lfsr u_tx_crc (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .clear_in (tx_smf),
    .shift_in (ts),
    .data_in  (t_cpos ? 1'b0 : tx_next),
    .crc_out  (tx_crc)
  );

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_pos      <= '0;
      tx_frame    <= `LAST_FRAME;
      tx_crc_ref  <= '0;
      tx_inv      <= 1'b0;
      tx_data_out <= 1'b1;
    end else if (ts) begin
      tx_pos      <= tcur_pos;
      tx_frame    <= tf;
      tx_data_out <= tx_next;
      if (tx_smf) begin
        tx_crc_ref <= tx_crc;
        tx_inv     <= inv_new;
      end
    end
  end

  // register file
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl               <= '0;
      tx_spare           <= '1;
      crc_error_irq_mask <= 1'b0;
      crc_error_counter  <= '0;
    end else begin
      if (wr & hit_ctrl) begin
        ctrl <= ctrl_t'(pwdata_in[$bits(ctrl_t)-1:0]);
      end
      if (wr & hit_sp) begin
        tx_spare <= tx_spare_t'(pwdata_in[$bits(tx_spare_t)-1:0]);
      end
      if (wr & hit_mask) begin
        crc_error_irq_mask <= pwdata_in[0];
      end
      if (cec_inc) begin
        crc_error_counter <= (wr & hit_cec) ? CEC_WIDTH'(1) :
                             CEC_WIDTH'(crc_error_counter + 1'b1);
      end else if (wr & hit_cec) begin
        crc_error_counter <= '0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < `NAT_BITS; i++) begin
        tx_national_bit_regs[i] <= '1;
      end
    end else if (wr & tx_sa_hit) begin
      tx_national_bit_regs[sa_idx] <= pwdata_in[7:0];
    end
  end

  status_t status;
  assign status = '{
    rx_ebit_frame15:            rx_ebit_frame15,
    rx_ebit_frame13:            rx_ebit_frame13,
    multiframe_align_lost_flag: multiframe_align_lost_out,
    frame_align_lost_flag:      frame_align_lost_in
  };

  wire [31:0] rd_data =
    hit_ctrl  ? 32'(ctrl) :
    hit_sp    ? 32'(tx_spare) :
    hit_st    ? 32'(status) :
    hit_irq   ? 32'(irq) :
    hit_mask  ? 32'(crc_error_irq_mask) :
    hit_cec   ? 32'(crc_error_counter) :
    tx_sa_hit ? 32'(tx_national_bit_regs[sa_idx]) :
    rx_sa_hit ? 32'(rx_national_bit_regs[sa_idx]) : 32'h0000_0000;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prdata_out <= '0;
    end else if (setup) begin
      prdata_out <= rd_data;
    end
  end

endmodule : crc4_multiframe_align

// [crc4_line_model.sv]
module crc4_line_model (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic bad_crc_in,
  input  wire logic bad_mfa_in,
  output logic      bit_en_out,
  output logic      frame_start_out,
  output logic      fas_frame_out,
  output logic      data_out,
  output logic      smf_start_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] mfa_word = 6'h0b;
  logic [11:0] pos;
  logic [3:0]  crc;
  logic [3:0]  sent;
  logic [7:0]  lfsr;
  logic        bad;
  logic        din;
  logic        fb;
  wire  [3:0]  fr = pos[11:8];
  wire         head = pos[7:0] == 8'h00;
  wire         last = pos[10:0] == 11'h7ff;
  wire  [3:0]  next_crc = {crc[2:1], crc[0] ^ fb, fb};
  // c bits in even frames, pattern then e bits in odd frames
  assign data_out = !head ? lfsr[0] : !fr[0] ? sent[~fr[2:1]] ^ bad :
    fr > 4'hb ? !fr[1] : mfa_word[3'h5 - fr[3:1]] ^ (bad_mfa_in &&
    fr == 4'hb);
  assign din = head && !fr[0] ? 1'b0 : data_out;
  assign fb = din ^ crc[3];
  assign frame_start_out = bit_en_out && head;
  assign fas_frame_out = !fr[0];
  assign smf_start_out = bit_en_out && pos[10:0] == 11'h0;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bit_en_out <= 1'b0;
      pos <= 12'h0;
      crc <= 4'h0;
      sent <= 4'h0;
      bad <= 1'b0;
      lfsr <= 8'he1;
    end else begin
      bit_en_out <= !bit_en_out;
      if (bit_en_out) begin
        pos <= pos + 12'h1;
        lfsr <= {lfsr[0] ^ lfsr[2] ^ lfsr[3] ^ lfsr[4], lfsr[7:1]};
        crc <= last ? 4'h0 : next_crc;
        if (last) begin
          sent <= next_crc;
          bad <= bad_crc_in;
        end
      end
    end
  end
endmodule : crc4_line_model

// [crc4_multiframe_align_monitor.sv]
module crc4_multiframe_align_monitor (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic frame_align_lost_in,
  input wire logic rx_frame_start_in,
  input wire logic tx_bit_en_in,
  input wire logic hdlc_tx_take_out,
  input wire logic tx_data_out,
  input wire logic multiframe_align_lost_out,
  input wire logic frame_resync_req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  ready_high_a:
    assert property (pready_out) else $error("pready low");
  slverr_access_a:
    assert property (pslverr_out |-> psel_in && penable_in)
    else $error("slverr outside access");
  lmfa_on_lfa_a:
    assert property (frame_align_lost_in |-> ##[0:2] multiframe_align_lost_out)
    else $error("lmfa not set");
  lmfa_fall_frame_a:
    assert property ($fell(multiframe_align_lost_out) |->
      $past(rx_frame_start_in) || $past(rx_frame_start_in, 2))
    else $error("lmfa fell off frame");
  lmfa_fall_aligned_a:
    assert property ($fell(multiframe_align_lost_out) |->
      !$past(frame_align_lost_in)) else $error("lmfa fell in lfa");
  tx_hold_a:
    assert property (!$past(tx_bit_en_in) |-> $stable(tx_data_out))
    else $error("tx moved without strobe");
  take_strobe_a:
    assert property (hdlc_tx_take_out |-> tx_bit_en_in)
    else $error("take without strobe");
  resync_pulse_a:
    assert property (frame_resync_req_out |=> !frame_resync_req_out)
    else $error("resync not a pulse");
  cover property ($fell(multiframe_align_lost_out));
  cover property (frame_resync_req_out);
  cover property (pslverr_out);
endmodule : crc4_multiframe_align_monitor
bind crc4_multiframe_align crc4_multiframe_align_monitor i_mon (
  .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .frame_align_lost_in(frame_align_lost_in),
  .rx_frame_start_in(rx_frame_start_in), .tx_bit_en_in(tx_bit_en_in),
  .hdlc_tx_take_out(hdlc_tx_take_out), .tx_data_out(tx_data_out),
  .multiframe_align_lost_out(multiframe_align_lost_out),
  .frame_resync_req_out(frame_resync_req_out));

// [test_crc4_multiframe_align.sv]
`include "crc4_map.svh"
module test_crc4_multiframe_align;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        psel, penable, pwrite, lost, recov, bcrc, bmfa, sysd, e;
  logic [7:0]  paddr, txw, tpos;
  logic        txd;
  logic [31:0] pwdata, prdata, r, v;
  logic        pready, pslverr, ben, fst, fas, rxd, smf, lmfa, rsq;
  int          n_fail = 0;
  int          compares = 0;
  int          n;
  always #12.5 clk_in = !clk_in;
  // txw collects the line bits sent, tpos is the strobe count in the frame
  always @(posedge clk_in) begin
    if (ben) begin
      txw <= {txw[6:0], txd};
      tpos <= fst ? 8'h00 : 8'(tpos + 8'h01);
    end
  end
  crc4_line_model i_far (.clk_in(clk_in), .srst_in(srst_in),
    .bad_crc_in(bcrc), .bad_mfa_in(bmfa), .bit_en_out(ben),
    .frame_start_out(fst), .fas_frame_out(fas), .data_out(rxd),
    .smf_start_out(smf));
  crc4_multiframe_align i_dut (.clk_in(clk_in), .srst_in(srst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .rx_bit_en_in(ben),
    .rx_frame_start_in(fst), .rx_fas_frame_in(fas), .rx_data_in(rxd),
    .frame_align_lost_in(lost), .frame_recovery_in(recov),
    .tx_bit_en_in(ben), .tx_frame_start_in(fst), .system_tx_data_in(sysd),
    .hdlc_tx_data_in(rxd), .hdlc_tx_take_out(), .tx_data_out(txd),
    .multiframe_align_lost_out(lmfa), .frame_resync_req_out(rsq));
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic tout;
    n_fail++;
    close_out();
  endtask : tout
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1)
      tout();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask : rd
  task automatic wait_on(input int sel, input int lim);
    logic hit;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
      hit = sel == 0 ? !lmfa : sel == 1 ? rsq : smf;
    end while (hit !== 1'b1 && n < lim);
    if (hit !== 1'b1)
      tout();
  endtask : wait_on
  // time slot 0 of the next even frame, as sent on the line
  task automatic ts0(input logic [7:0] m, input logic [7:0] x);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (!(ben === 1'b1 && tpos === 8'h08 && fas === 1'b1) && n < 1100);
    if (n >= 1100)
      tout();
    chk({24'h0, txw & m}, {24'h0, x});
  endtask : ts0
  initial begin
    {psel, penable, pwrite, bcrc, bmfa, sysd, recov, e} = '0;
    lost = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    r = $urandom(32'h129e54a9);
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(`OFS_CTRL, '1, 32'h0);
    rd(`OFS_TX_SPARE, '1, 32'h1ff);
    rd(`OFS_CEC, '1, 32'h0);
    rd(`OFS_CMD, '1, 32'h0);
    for (int k = 0; k < 5; k++) begin
      rd(`OFS_TX_SA + 8'(4 * k), '1, 32'hff);
      v = $urandom;
      apb(1'b1, `OFS_TX_SA + 8'(4 * k), v);
      rd(`OFS_TX_SA + 8'(4 * k), '1, v & 32'hff);
    end
    apb(1'b0, 8'hfc, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test registers done");
    apb(1'b1, `OFS_MASK, 32'h1);
    apb(1'b1, `OFS_CTRL, 32'h1f009);
    lost <= 1'b0;
    recov <= 1'b1;
    @(posedge clk_in);
    recov <= 1'b0;
    wait_on(0, 20480);
    wait_on(2, 4200);
    rd(`OFS_STATUS, '1, 32'h4);
    rd(`OFS_IRQ, 32'h11, 32'h10);
    apb(1'b1, `OFS_IRQ, '1);
    wait_on(2, 4200);
    rd(`OFS_CEC, '1, 32'h0);
    bcrc <= 1'b1;
    wait_on(2, 4200);
    wait_on(2, 4200);
    bcrc <= 1'b0;
    wait_on(2, 4200);
    wait_on(2, 4200);
    rd(`OFS_CEC, '1, 32'h2);
    rd(`OFS_IRQ, 32'h1, 32'h1);
    $display("test sync and crc done");
    apb(1'b1, `OFS_IRQ, '1);
    lost <= 1'b1;
    rd(`OFS_STATUS, 32'h3, 32'h3);
    rd(`OFS_IRQ, 32'h6, 32'h6);
    bmfa <= 1'b1;
    lost <= 1'b0;
    apb(1'b1, `OFS_CMD, 32'h2);
    wait_on(1, 34000);
    chk(n >= 63 * 512 && n <= 66 * 512, 32'h1);
    rd(`OFS_IRQ, 32'h20, 32'h20);
    rd(`OFS_STATUS, 32'h2, 32'h2);
    apb(1'b1, `OFS_CMD, 32'h1);
    wait_on(1, 8);
    $display("test search window done");
    ts0(8'h7f, 8'h1b);
    apb(1'b1, `OFS_CTRL, 32'h81);
    wait_on(2, 4200);
    ts0(8'hff, 8'h00);
    $display("test transmit slot done");
    close_out();
  end
endmodule : test_crc4_multiframe_align
